// >>> pio_consts.svh
// Purpose: Constants of the parallel port bank: offsets, masks, resets.
// Assumes: Eight port slots of eight bits each, slot k at byte 0x20*k.
// Notes:   Slot order P0 P1 P2 P4 P7 P8 P9 PB; masks show which bits exist.
`ifndef PIO_CONSTS_SVH
`define PIO_CONSTS_SVH

`define PIO_ADDR_W     8
`define PIO_PINS       42
`define PIO_SLOTS      64

// Register index inside a port slot (address bits 4:2)
`define PIO_REG_DR     3'h0
`define PIO_REG_PRD    3'h1
`define PIO_REG_CR     3'h2
`define PIO_REG_FC     3'h3
`define PIO_REG_OC     3'h4
`define PIO_REG_PU     3'h5

// Implemented bits per control, port P0 in the low byte
`define PIO_MASK_PIN   64'hF0030FFFFFFF0F0F
`define PIO_MASK_CR    64'hF0030FFFFFFF0F0F
`define PIO_MASK_FC    64'hF0030F1FFFFF0005
`define PIO_MASK_OC    64'hF003000000FF0000
`define PIO_MASK_PU    64'hF0030FFFFFFF0F0C

`define PIO_RST_REG    64'h0000000000000000

`define PIO_RESP_OKAY  2'h0
`define PIO_RESP_ERR   2'h2

`endif

// >>> pio_pkg.sv
// Purpose: Types and helper functions of the parallel port bank.
// Assumes: pio_consts.svh supplies all numbers.
// Notes:   State of the top is one packed struct.
`include "pio_consts.svh"

package pio_pkg;

    typedef logic [`PIO_SLOTS-1:0] pio_slot_t;
    typedef logic [`PIO_PINS-1:0]  pio_pin_t;

    typedef struct packed {
        pio_slot_t               dr;
        pio_slot_t               cr;
        pio_slot_t               fc;
        pio_slot_t               oc;
        pio_slot_t               pu;
        pio_slot_t               pin_o;
        pio_slot_t               pin_oe;
        pio_slot_t               pin_pe;
        pio_slot_t               alt_in;
        logic                    aw_have;
        logic                    w_have;
        logic [`PIO_ADDR_W-1:0]  awaddr;
        logic [7:0]              wdata;
        logic                    wstrb0;
        logic                    awready;
        logic                    wready;
        logic                    bvalid;
        logic [1:0]              bresp;
        logic                    arready;
        logic                    rvalid;
        logic [7:0]              rdata;
        logic [1:0]              rresp;
    } pio_state_t;

    // Compact pin number of a slot: count of implemented slots below it
    function automatic int pio_pin_pos(input pio_slot_t mask, input int slot);
        int n;
        n = 0;
        for (int i = 0; i < slot; i++) begin
            if (mask[i]) begin
                n = n + 1;
            end
        end
        return n;
    endfunction

    // Replace one port byte, touching only bits that exist there
    function automatic pio_slot_t pio_wr_byte(input pio_slot_t old, input logic [2:0] port,
                                              input logic [7:0] data, input pio_slot_t mask);
        pio_slot_t r;
        r = old;
        for (int b = 0; b < 8; b++) begin
            if (mask[{port, 3'(b)}]) begin
                r[{port, 3'(b)}] = data[b];
            end
        end
        return r;
    endfunction

endpackage

// >>> pio_pad_logic.sv
// Purpose: Per-pin drive, enable and pull-up decision for all slots.
// Assumes: Control inputs are register values; purely combinational.
// Notes:   The caller registers the results before they reach the pads.
`timescale 1ns/1ps
`default_nettype none

module pio_pad_logic
    import pio_pkg::*;
(
    input  wire pio_pkg::pio_slot_t dr,
    input  wire pio_pkg::pio_slot_t cr,
    input  wire pio_pkg::pio_slot_t fc,
    input  wire pio_pkg::pio_slot_t oc,
    input  wire pio_pkg::pio_slot_t pu,
    input  wire pio_pkg::pio_slot_t alt_out,
    output logic [63:0]             pad_o,
    output logic [63:0]             pad_oe,
    output logic [63:0]             pad_pe
);
    pio_slot_t val;

    // Data source, level driven and enable for each slot
    always_comb begin
        val    = (fc & alt_out) | (~fc & dr);
        pad_o  = val & ~oc;
        pad_oe = cr & (~oc | ~val);
        pad_pe = pu & (~cr | oc);
    end

endmodule

`default_nettype wire

// >>> pio_rd_mux.sv
// Purpose: Read data and error answer for one register address.
// Assumes: Pins arrive already spread into slot positions.
// Notes:   Pin state is taken straight from the pins, never stored.
`timescale 1ns/1ps
`default_nettype none
`include "pio_consts.svh"

module pio_rd_mux
    import pio_pkg::*;
(
    input  wire logic [`PIO_ADDR_W-1:0] addr,
    input  wire pio_pkg::pio_slot_t     dr,
    input  wire pio_pkg::pio_slot_t     cr,
    input  wire pio_pkg::pio_slot_t     fc,
    input  wire pio_pkg::pio_slot_t     oc,
    input  wire pio_pkg::pio_slot_t     pu,
    input  wire pio_pkg::pio_slot_t     pins,
    output logic [7:0]                  rdata,
    output logic                        err
);
    logic [2:0] port;
    logic [2:0] idx;

    // Decode slot and register; absent bits of a port read zero
    always_comb begin
        port  = addr[7:5];
        idx   = addr[4:2];
        err   = 1'b0;
        rdata = 8'h00;
        unique case (idx)
            `PIO_REG_DR:  rdata = dr[{port, 3'h0} +: 8];
            `PIO_REG_PRD: rdata = pins[{port, 3'h0} +: 8];
            `PIO_REG_CR:  rdata = cr[{port, 3'h0} +: 8];
            `PIO_REG_FC:  rdata = fc[{port, 3'h0} +: 8];
            `PIO_REG_OC:  rdata = oc[{port, 3'h0} +: 8];
            `PIO_REG_PU:  rdata = pu[{port, 3'h0} +: 8];
            default:      err   = 1'b1;
        endcase
    end

endmodule

`default_nettype wire

// >>> pio_port_bank.sv
// Purpose: Eight-port parallel I/O bank behind an AXI4-Lite slave.
// Assumes: Pins are synchronous to clk_sys; one write, one read at once.
// Notes:   Registers sit 0x20 bytes apart per port, one byte per word.
//
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pio_consts.svh"

module pio_port_bank
    import pio_pkg::*;
(
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    // AXI4-Lite write address
    input  wire logic [`PIO_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]             s_axi_awprot,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [`PIO_ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]             s_axi_arprot,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // Pads: level in, level out, drive enable, pull-up enable
    input  wire logic [`PIO_PINS-1:0]   pin_i,
    output logic [`PIO_PINS-1:0]        pin_o,
    output logic [`PIO_PINS-1:0]        pin_oe,
    output logic [`PIO_PINS-1:0]        pin_pu_en,
    // Peripheral side of the secondary functions
    input  wire logic [`PIO_PINS-1:0]   alt_out,
    output logic [`PIO_PINS-1:0]        alt_in
);
    import pio_pkg::*;

    localparam pio_slot_t PIN_MASK = `PIO_MASK_PIN;

    pio_state_t s_q;
    pio_state_t s_d;

    pio_slot_t  pin_slot;
    pio_slot_t  alt_slot;
    logic [63:0] pad_o;
    logic [63:0] pad_oe;
    logic [63:0] pad_pe;
    logic [7:0]  rd_byte;
    logic        rd_err;
    logic [2:0]  wr_port;
    logic [2:0]  wr_idx;

    // Protection bits and upper data lanes carry nothing here
    logic        unused_ok;
    assign unused_ok = ^{s_axi_awprot, s_axi_arprot, s_axi_wdata[31:8], s_axi_wstrb[3:1]};

    // Spread the 42 pads over the 64 slots; absent slots read zero
    for (genvar s = 0; s < `PIO_SLOTS; s++) begin : g_slot
        if (PIN_MASK[s]) begin : g_pin
            localparam int P = pio_pin_pos(PIN_MASK, s);
            assign pin_slot[s] = pin_i[P];
            assign alt_slot[s] = alt_out[P];
            assign pin_o[P]     = s_q.pin_o[s];
            assign pin_oe[P]    = s_q.pin_oe[s];
            assign pin_pu_en[P] = s_q.pin_pe[s];
            assign alt_in[P]    = s_q.alt_in[s];
        end else begin : g_none
            assign pin_slot[s] = 1'b0;
            assign alt_slot[s] = 1'b0;
        end
    end

    // Pad decisions are made on stored controls, then registered once more
    pio_pad_logic u_pad (
        .dr      (s_q.dr),
        .cr      (s_q.cr),
        .fc      (s_q.fc),
        .oc      (s_q.oc),
        .pu      (s_q.pu),
        .alt_out (alt_slot),
        .pad_o   (pad_o),
        .pad_oe  (pad_oe),
        .pad_pe  (pad_pe)
    );

    // Read data is formed from the pins at the edge that takes the address
    pio_rd_mux u_rd (
        .addr  (s_axi_araddr),
        .dr    (s_q.dr),
        .cr    (s_q.cr),
        .fc    (s_q.fc),
        .oc    (s_q.oc),
        .pu    (s_q.pu),
        .pins  (pin_slot),
        .rdata (rd_byte),
        .err   (rd_err)
    );

    assign wr_port = s_q.awaddr[7:5];
    assign wr_idx  = s_q.awaddr[4:2];

    // Bus outputs straight from the state register
    assign s_axi_awready = s_q.awready;
    assign s_axi_wready  = s_q.wready;
    assign s_axi_bvalid  = s_q.bvalid;
    assign s_axi_bresp   = s_q.bresp;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rvalid  = s_q.rvalid;
    assign s_axi_rresp   = s_q.rresp;
    assign s_axi_rdata   = {24'h000000, s_q.rdata};

    // Next state: bus handshakes, register writes and pad registers
    always_comb begin
        s_d = s_q;

        // Address and data are taken independently, in either order
        if (s_axi_awvalid && s_q.awready) begin
            s_d.aw_have = 1'b1;
            s_d.awaddr  = s_axi_awaddr;
            s_d.awready = 1'b0;
        end
        if (s_axi_wvalid && s_q.wready) begin
            s_d.w_have = 1'b1;
            s_d.wdata  = s_axi_wdata[7:0];
            s_d.wstrb0 = s_axi_wstrb[0];
            s_d.wready = 1'b0;
        end

        // Both halves held: store the byte and raise the response
        if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
            s_d.aw_have = 1'b0;
            s_d.w_have  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = `PIO_RESP_OKAY;
            // A cleared lane-0 strobe leaves the register untouched
            if (s_q.wstrb0) begin
                unique case (wr_idx)
                    `PIO_REG_DR: begin
                        // Latch keeps its value until the next write
                        s_d.dr = pio_wr_byte(s_q.dr, wr_port, s_q.wdata,
                                             `PIO_MASK_PIN);
                    end
                    `PIO_REG_PRD: begin
                        // Pin state is read-only; the write is dropped
                        s_d.dr = s_q.dr;
                    end
                    `PIO_REG_CR: begin
                        s_d.cr = pio_wr_byte(s_q.cr, wr_port, s_q.wdata,
                                             `PIO_MASK_CR);
                    end
                    `PIO_REG_FC: begin
                        s_d.fc = pio_wr_byte(s_q.fc, wr_port, s_q.wdata,
                                             `PIO_MASK_FC);
                    end
                    `PIO_REG_OC: begin
                        s_d.oc = pio_wr_byte(s_q.oc, wr_port, s_q.wdata,
                                             `PIO_MASK_OC);
                    end
                    `PIO_REG_PU: begin
                        s_d.pu = pio_wr_byte(s_q.pu, wr_port, s_q.wdata,
                                             `PIO_MASK_PU);
                    end
                    default: begin
                        s_d.bresp = `PIO_RESP_ERR;
                    end
                endcase
            end else if (wr_idx > `PIO_REG_PU) begin
                s_d.bresp = `PIO_RESP_ERR;
            end
        end

        // Response accepted: reopen both write channels
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid  = 1'b0;
            s_d.awready = 1'b1;
            s_d.wready  = 1'b1;
        end

        // Read: the pins are sampled only at the taking edge, no strobe shows it
        if (s_axi_arvalid && s_q.arready) begin
            s_d.arready = 1'b0;
            s_d.rvalid  = 1'b1;
            s_d.rdata   = rd_byte;
            s_d.rresp   = rd_err ? `PIO_RESP_ERR : `PIO_RESP_OKAY;
        end
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid  = 1'b0;
            s_d.arready = 1'b1;
        end

        // Pads follow the stored controls one cycle after the write cycle
        s_d.pin_o  = pad_o & PIN_MASK;
        s_d.pin_oe = pad_oe & PIN_MASK;
        s_d.pin_pe = pad_pe & PIN_MASK;

        // Peripherals see the pad level whatever the function enable says
        s_d.alt_in = pin_slot;
    end

    // State register; reset leaves every pad undriven
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_q         <= '0;
            s_q.dr      <= `PIO_RST_REG;
            s_q.cr      <= `PIO_RST_REG;
            s_q.fc      <= `PIO_RST_REG;
            s_q.oc      <= `PIO_RST_REG;
            s_q.pu      <= `PIO_RST_REG;
            s_q.awready <= 1'b1;
            s_q.wready  <= 1'b1;
            s_q.arready <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

endmodule

`default_nettype wire

// >>> pio_port_bank_checker.sv
// Purpose: Bus handshake and pad timing checks on the port bank top.
// Assumes: One clock domain; rst_n asynchronous, active low.
// Notes:   Bound into every pio_port_bank instance.
`timescale 1ns/1ps
`default_nettype none
`include "pio_consts.svh"

module pio_port_bank_checker (
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,
    input  wire logic                 s_axi_awvalid,
    input  wire logic                 s_axi_awready,
    input  wire logic                 s_axi_wvalid,
    input  wire logic                 s_axi_wready,
    input  wire logic                 s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic                 s_axi_arvalid,
    input  wire logic                 s_axi_arready,
    input  wire logic                 s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    input  wire logic [`PIO_PINS-1:0] pin_i,
    input  wire logic [`PIO_PINS-1:0] pin_o,
    input  wire logic [`PIO_PINS-1:0] pin_oe,
    input  wire logic [`PIO_PINS-1:0] pin_pu_en,
    input  wire logic [`PIO_PINS-1:0] alt_in
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // Nothing driven and no pull-up until software asks for it
    property p_rst_idle; $rose(rst_n) |-> pin_oe == '0 && pin_pu_en == '0; endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("pads active after reset");
    // Peripheral inputs see the pad one edge later, whatever the mode
    property p_alt_in; $past(rst_n) |-> alt_in == $past(pin_i); endproperty
    a_alt_in: assert property (p_alt_in) else $error("alt_in not pad level");
    // Pull-up enables move only on the edge after a register store
    property p_pad_step; $changed(pin_pu_en) |-> $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2);
    endproperty
    a_pad_step: assert property (p_pad_step) else $error("pad changed off its slot");
    // A pull-up never fights an actively driven high level
    property p_pu_high; (pin_pu_en & pin_oe & pin_o) == '0; endproperty
    a_pu_high: assert property (p_pu_high) else $error("pull-up on driven high");
    property p_wr_resp; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_bvalid ##1 s_axi_bvalid; endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write answer late or early");
    property p_aw_hold; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
    a_aw_hold: assert property (p_aw_hold) else $error("second write address taken");
    property p_b_done; s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid && s_axi_awready && s_axi_wready; endproperty
    a_b_done: assert property (p_b_done) else $error("write channel not freed");
    // Read answer in the cycle after the address is taken
    property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer not prompt");
    property p_r_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
    endproperty
    a_r_done: assert property (p_r_done) else $error("read channel not freed");
endmodule

bind pio_port_bank pio_port_bank_checker u_chk (
    .clk_sys, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .pin_i, .pin_o, .pin_oe, .pin_pu_en, .alt_in
);
`default_nettype wire

// >>> pio_board_model.sv
// Purpose: Board around the pads: external drivers, pull-ups, open lines.
// Assumes: Bench never drives a pin that the device drives.
// Notes:   An open line with no pull-up toggles every cycle.
`timescale 1ns/1ps
`default_nettype none
`include "pio_consts.svh"

module pio_board_model (
    input  wire logic                 clk_sys,
    input  wire logic [`PIO_PINS-1:0] pin_o,
    input  wire logic [`PIO_PINS-1:0] pin_oe,
    input  wire logic [`PIO_PINS-1:0] pin_pu_en,
    input  wire logic [`PIO_PINS-1:0] ext_val,
    input  wire logic [`PIO_PINS-1:0] ext_en,
    output logic [`PIO_PINS-1:0]      pin_i
);
    logic [`PIO_PINS-1:0] float_q = '0;

    // A released line must not keep a stale level the design could lean on
    always @(posedge clk_sys) begin
        float_q <= ~float_q;
    end

    // Device drive first, then the board source, then pull-up, else noise
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_val)
                 | (~pin_oe & ~ext_en & (pin_pu_en | float_q));
endmodule
`default_nettype wire

// >>> pio_port_bank_tb_top.sv
// Purpose: Self-checking bench for the parallel port bank.
// Assumes: AXI4-Lite master here, board model on the pads.
// Notes:   Pads are checked 1 ns after a write so the pad register edge after the store has landed.
`timescale 1ns/1ps
`default_nettype none
`include "pio_consts.svh"

module pio_port_bank_tb_top;
    logic                 clk_sys = 1'b0;
    logic                 rst_n = 1'b0;
    logic [7:0]           s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0]          s_axi_wdata = 32'h0, s_axi_rdata;
    logic                 s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic                 s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic                 s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]           s_axi_bresp, s_axi_rresp;
    logic [`PIO_PINS-1:0] pin_i, pin_o, pin_oe, pin_pu_en, alt_in;
    logic [`PIO_PINS-1:0] alt_out = '0, ext_val = '0, ext_en = '0;
    int                   bad_count = 0, cmp_count = 0, cyc = 0;

    always #5 clk_sys = ~clk_sys;

    pio_port_bank uut (
        .clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .pin_i, .pin_o, .pin_oe, .pin_pu_en, .alt_out, .alt_in
    );
    pio_board_model u_board (.clk_sys, .pin_o, .pin_oe, .pin_pu_en, .ext_val, .ext_en, .pin_i);

    task automatic end_of_test();
        if (bad_count == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [`PIO_PINS-1:0] got, input logic [`PIO_PINS-1:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Board levels and peripheral outputs change together on an edge
    task automatic drive(input logic [41:0] v, input logic [41:0] en, input logic [41:0] ao);
        @(posedge clk_sys);
        ext_val <= v;
        ext_en  <= en;
        alt_out <= ao;
    endtask

    // Address and data offered together; bready held until bvalid is seen
    task automatic axw(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge clk_sys);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk(42'(s_axi_bresp), 42'(er));
        #1;
    endtask

    task automatic axr(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
        @(posedge clk_sys);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(42'(s_axi_rdata), 42'(ed));
        chk(42'(s_axi_rresp), 42'(er));
    endtask

    task automatic t_reset_map();
        logic [7:0] m [8] = '{8'h0F, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h03, 8'hF0};
        chk(pin_oe, '0);
        chk(pin_pu_en, '0);
        drive('1, '1, '0);
        // Oscillator pair stays out of port traffic, so slot 0 is skipped
        for (int k = 1; k < 8; k++) axr(8'(k * 32 + 4), m[k], `PIO_RESP_OKAY);
        axr(8'h48, 8'h00, `PIO_RESP_OKAY);
        axr(8'h1C, 8'h00, `PIO_RESP_ERR);
    endtask

    task automatic t_p2_modes();
        drive('0, '0, '0);
        axw(8'h50, 8'hFF, `PIO_RESP_OKAY);
        axw(8'h54, 8'hFF, `PIO_RESP_OKAY);
        axw(8'h40, 8'h0F, `PIO_RESP_OKAY);
        axw(8'h48, 8'hFF, `PIO_RESP_OKAY);
        chk(42'(pin_oe[15:8]), 42'hF0);
        chk(42'(pin_o[15:8]), 42'h00);
        chk(42'(pin_pu_en[15:8]), 42'hFF);
        axr(8'h44, 8'h0F, `PIO_RESP_OKAY);
        axw(8'h50, 8'h00, `PIO_RESP_OKAY);
        chk(42'(pin_oe[15:8]), 42'hFF);
        chk(42'(pin_o[15:8]), 42'h0F);
        chk(42'(pin_pu_en[15:8]), 42'h00);
        axw(8'h48, 8'h00, `PIO_RESP_OKAY);
        chk(42'(pin_oe[15:8]), 42'h00);
        axr(8'h40, 8'h0F, `PIO_RESP_OKAY);
    endtask

    // Each value read once, after the board has settled it
    task automatic t_input();
        drive(42'h3C << 16, 42'hFF << 16, '0);
        axr(8'h64, 8'h3C, `PIO_RESP_OKAY);
        chk(42'(alt_in[23:16]), 42'h3C);
        axw(8'h6C, 8'hFF, `PIO_RESP_OKAY);
        drive(42'hC3 << 16, 42'hFF << 16, '0);
        axr(8'h64, 8'hC3, `PIO_RESP_OKAY);
        chk(42'(alt_in[23:16]), 42'hC3);
    endtask

    // Only bits 4:0 of this port carry a function enable; bits 7:5 keep the latch
    task automatic t_alt();
        drive('0, '0, 42'h5A << 24);
        axw(8'h80, 8'h0F, `PIO_RESP_OKAY);
        axw(8'h88, 8'hFF, `PIO_RESP_OKAY);
        chk(42'(pin_o[31:24]), 42'h0F);
        axw(8'h8C, 8'hFF, `PIO_RESP_OKAY);
        chk(42'(pin_o[31:24]), 42'h1A);
        drive('0, '0, 42'hA5 << 24);
        axr(8'h84, 8'h05, `PIO_RESP_OKAY);
        axw(8'h8C, 8'h00, `PIO_RESP_OKAY);
        chk(42'(pin_o[31:24]), 42'h0F);
    endtask

    // Absent control bits drop writes; a reserved word answers with an error
    task automatic t_ctrl_map();
        logic [7:0] a [7] = '{8'h14, 8'h2C, 8'h30, 8'hAC, 8'hC8, 8'h18, 8'hF4};
        logic [7:0] e [7] = '{8'h0C, 8'h00, 8'h00, 8'h0F, 8'h03, 8'h00, 8'hF0};
        logic [1:0] r;
        for (int i = 0; i < 7; i++) begin
            r = (a[i] == 8'h18) ? `PIO_RESP_ERR : `PIO_RESP_OKAY;
            axw(a[i], 8'hFF, r);
            axr(a[i], e[i], r);
        end
    endtask

    // Hang guard: about 150 cycles are needed, the ceiling is ample
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            bad_count++;
            end_of_test();
        end
    end

    initial begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset_map();
        t_p2_modes();
        t_input();
        t_alt();
        t_ctrl_map();
        end_of_test();
    end
endmodule
`default_nettype wire
